// ==== src/csi_sequencer.sv ====
// Cut line sequencing and interlock top level
`timescale 1ns/1ps
module csi_sequencer
  import csi_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdData,
  input  wire logic [1:0]        machineType,
  input  wire logic              runContact,
  input  wire logic              safetyOk,
  input  wire logic              overload,
  input  wire logic              encPulse,
  input  wire logic              carriageInTol,
  input  wire logic [CNT_W-1:0]  carriagePos,
  input  wire logic              jogAhead,
  input  wire logic              jogBack,
  input  wire logic              manualCycle,
  output logic                   runOut,
  output logic [SPD_N-1:0]       speedOut,
  output logic                   shearFire,
  output logic                   pressFire,
  output logic [PRESS_N-1:0]     pressSel,
  output logic [GAG_N-1:0]       gagSel,
  output logic                   carriageFollow,
  output logic                   carriageFwd,
  output logic                   carriageRev,
  output logic [JOG_W-1:0]       carriageJogSpeed,
  output logic                   formerFwd,
  output logic                   formerRev
);
  // ****************************************
  // Registers
  // ****************************************
  logic [5:0]         ctrl_ff;
  logic [CNT_W-1:0]   lineSpeed_ff;
  logic [CNT_W-1:0]   partLen_ff;
  logic [CNT_W-1:0]   minTravel_ff;
  logic [JOG_W-1:0]   jogSpeed_ff;
  logic [CNT_W-1:0]   piecesLeft_ff;
  logic [CNT_W-1:0]   changePt_ff;
  logic [PRESS_N-1:0] pressCfg_ff;
  logic [GAG_N-1:0]   gagCfg_ff;
  logic               tolFault_ff;
  logic               tolErr_ff;
  logic               orderDone_ff;
  logic [CNT_W-1:0]   position_ff;
  logic [CNT_W-1:0]   lengthCnt_ff;
  logic               cutPending_ff;
  logic [DATA_W-1:0]  rdData_ff;
  csi_state_t         state_ff;
  csi_state_t         nxt_state;

  logic simRun;
  logic isRun;
  logic isJog;
  logic linePulse;
  logic interlockOk;
  logic jobOk;
  logic orderEnd;
  logic atTol;
  logic atMinTravel;
  logic autoCut;
  logic autoWithheld;
  logic tolEvent;
  logic manualCrop;
  logic manualPress;
  logic cutDone;
  logic wrStatus;
  logic runFast;

  csi_pulse_if pgBus ();

  assign simRun = ctrl_ff[CTRL_SIM];
  assign isRun  = (state_ff == ST_RUN_S);
  assign isJog  = (state_ff == ST_JOG_S);

  // ****************************************
  // Simulated encoder
  // ****************************************
  // [RULE20] Enable only in simulated run
  assign pgBus.enable    = simRun && isRun;
  assign pgBus.increment = lineSpeed_ff;

  csi_pulse_gen u_pulse_gen (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .pg      (pgBus.gen)
  );

  // [RULE1] Synthetic pulses replace encoder
  assign linePulse = simRun ? pgBus.pulse : encPulse;

  // ****************************************
  // Interlocks
  // ****************************************
  // [RULE14] Estop and overload
  // [RULE17] Run circuit or interlock
  assign interlockOk = runContact && safetyOk && !overload;
  assign jobOk       = ctrl_ff[CTRL_JOB] && (piecesLeft_ff != CNT_ZERO);
  // [RULE8] Final piece change point
  assign orderEnd    = (piecesLeft_ff == ONE_PIECE) && (lengthCnt_ff >= changePt_ff);

  // ****************************************
  // Cut window
  // ****************************************
  // [RULE4] Tolerance or minimum travel
  assign atTol       = cutPending_ff && carriageInTol;
  assign atMinTravel = cutPending_ff && !carriageInTol && (carriagePos >= minTravel_ff);
  assign tolEvent    = isRun && atMinTravel;
  // [RULE3] Withhold tolerance_fault cut
  assign autoWithheld = tolEvent && ctrl_ff[CTRL_NOCUT];
  // [RULE13] Automatic fire only in run
  assign autoCut      = isRun && (atTol || (atMinTravel && !ctrl_ff[CTRL_NOCUT]));
  assign cutDone      = autoCut || autoWithheld;

  // [RULE15] Machine type picks manual path
  // [RULE12] Crop while running, non-stop
  assign manualCrop  = manualCycle && !machineType[MT_FTS] && isRun;
  // [RULE11] Press only in halt, feed-to-stop
  assign manualPress = manualCycle && machineType[MT_FTS] && (state_ff == ST_HALT_S);

  // Slow down for the last piece so the stop lands on the change point
  assign runFast = isRun && (piecesLeft_ff != ONE_PIECE);

  // ****************************************
  // Machine state
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_HALT_S: begin
        // [RULE19] Run needs job and no error
        // [RULE10] Follow run contact
        if (interlockOk && jobOk && !tolErr_ff && !orderDone_ff) begin
          nxt_state = ST_RUN_S;
        end else if (jogAhead || jogBack) begin
          nxt_state = ST_JOG_S;
        end
      end
      ST_RUN_S: begin
        // [RULE2] Tolerance halts only outside sim
        if (!interlockOk || orderEnd || (tolEvent && !simRun)) begin
          nxt_state = ST_HALT_S;
        end
      end
      ST_JOG_S: begin
        // Jogging is a manual action; a run request wins only from halt
        if (!(jogAhead || jogBack)) begin
          nxt_state = ST_HALT_S;
        end
      end
      default: nxt_state = ST_HALT_S;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_HALT_S;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff      <= 6'h00;
      lineSpeed_ff <= CNT_ZERO;
      partLen_ff   <= CNT_ZERO;
      minTravel_ff <= CNT_ZERO;
      jogSpeed_ff  <= 8'h00;
      changePt_ff  <= CNT_ZERO;
      pressCfg_ff  <= 12'h000;
      gagCfg_ff    <= 64'h0000000000000000;
    end else if (regWr) begin
      unique case (regAddr)
        REG_CTRL:       ctrl_ff      <= regWrData[5:0];
        REG_LINE_SPEED: lineSpeed_ff <= regWrData[CNT_W-1:0];
        REG_PART_LEN:   partLen_ff   <= regWrData[CNT_W-1:0];
        REG_MIN_TRAVEL: minTravel_ff <= regWrData[CNT_W-1:0];
        REG_JOG_SPEED:  jogSpeed_ff  <= regWrData[JOG_W-1:0];
        REG_CHANGE_PT:  changePt_ff  <= regWrData[CNT_W-1:0];
        REG_PRESS:      pressCfg_ff  <= regWrData[PRESS_N-1:0];
        REG_GAG_LO:     gagCfg_ff[DATA_W-1:0] <= regWrData;
        REG_GAG_HI:     gagCfg_ff[GAG_N-1:DATA_W] <= regWrData;
        default: ;
      endcase
    end
  end

  // Pieces left: an automatic or withheld cut decrements it, a manual crop does not; a write reloads it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      piecesLeft_ff <= CNT_ZERO;
    end else if (regWr && (regAddr == REG_ORDER)) begin
      piecesLeft_ff <= regWrData[CNT_W-1:0];
    end else if (cutDone && (piecesLeft_ff != CNT_ZERO)) begin
      piecesLeft_ff <= piecesLeft_ff - CNT_ONE;
    end
  end

  // ****************************************
  // Sticky status
  // ****************************************
  assign wrStatus = regWr && (regAddr == REG_STATUS);

  // [RULE21] Fault flagged even in sim
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tolFault_ff <= 1'b0;
      tolErr_ff   <= 1'b0;
    end else begin
      if (tolEvent) begin
        tolFault_ff <= 1'b1;
      end else if (wrStatus && regWrData[ST_TOLF]) begin
        tolFault_ff <= 1'b0;
      end
      if (tolEvent && !simRun) begin
        tolErr_ff <= 1'b1;
      end else if (wrStatus && regWrData[ST_TOLF]) begin
        tolErr_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      orderDone_ff <= 1'b0;
    end else if (isRun && orderEnd) begin
      orderDone_ff <= 1'b1;
    end else if ((wrStatus && regWrData[ST_DONE]) || (regWr && (regAddr == REG_ORDER))) begin
      orderDone_ff <= 1'b0;
    end
  end

  // ****************************************
  // Length tracking
  // ****************************************
  // [RULE16] Count in every state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      position_ff <= CNT_ZERO;
    end else if (linePulse) begin
      position_ff <= position_ff + CNT_ONE;
    end
  end

  // Pending cut is held through halt and taken once running again
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lengthCnt_ff  <= CNT_ZERO;
      cutPending_ff <= 1'b0;
    end else begin
      if (linePulse) begin
        if (lengthCnt_ff + CNT_ONE >= partLen_ff) begin
          lengthCnt_ff  <= CNT_ZERO;
        end else begin
          lengthCnt_ff  <= lengthCnt_ff + CNT_ONE;
        end
      end
      if (linePulse && (lengthCnt_ff + CNT_ONE >= partLen_ff)) begin
        cutPending_ff <= 1'b1;
      end else if (cutDone) begin
        cutPending_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Firing outputs
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      shearFire      <= 1'b0;
      pressFire      <= 1'b0;
      pressSel       <= 12'h000;
      gagSel         <= 64'h0000000000000000;
      carriageFollow <= 1'b0;
    end else begin
      shearFire      <= autoCut || manualCrop;
      pressFire      <= manualPress;
      // [RULE18] Press and gag addressing
      pressSel       <= manualPress ? pressCfg_ff : 12'h000;
      gagSel         <= manualPress ? gagCfg_ff : 64'h0000000000000000;
      // [RULE1] Carriage paced by line pulses
      carriageFollow <= isRun && linePulse;
    end
  end

  // ****************************************
  // Jog outputs
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      carriageFwd      <= 1'b0;
      carriageRev      <= 1'b0;
      carriageJogSpeed <= 8'h00;
      formerFwd        <= 1'b0;
      formerRev        <= 1'b0;
    end else begin
      // [RULE5] Carriage forward at jog speed
      carriageFwd      <= isJog && ctrl_ff[CTRL_CJOG] && machineType[MT_DIE] && jogAhead;
      // [RULE6] Carriage reverse
      carriageRev      <= isJog && ctrl_ff[CTRL_CJOG] && machineType[MT_DIE] && jogBack && !jogAhead;
      carriageJogSpeed <= (isJog && ctrl_ff[CTRL_CJOG] && machineType[MT_DIE]) ? jogSpeed_ff : 8'h00;
      // [RULE7] Otherwise move roll former
      formerFwd        <= isJog && !(ctrl_ff[CTRL_CJOG] && machineType[MT_DIE]) && jogAhead;
      formerRev        <= isJog && !(ctrl_ff[CTRL_CJOG] && machineType[MT_DIE]) && jogBack && !jogAhead;
    end
  end

  // ****************************************
  // Speed control
  // ****************************************
  function automatic logic [SPD_N-1:0] speedMap(input logic [1:0] cfg, input logic fast, input logic run,
                                                input logic jogF, input logic jogR);
    logic [SPD_N-1:0] s;
    s = {SPD_N{1'b0}};
    s[SO_RUN] = run;
    s[SO_REV] = jogR;
    unique case (cfg)
      SPD_FWD_SLOW: begin
        s[SO_FWD]  = run || jogF;
        s[SO_SLOW] = !fast;
      end
      SPD_FAST_SLOW: begin
        s[SO_FWD]  = fast;
        s[SO_SLOW] = (run && !fast) || jogF || jogR;
      end
      SPD_RUN_MOVE: begin
        s[SO_FWD]  = run || jogF;
        s[SO_SLOW] = !fast;
        s[SO_RUN]  = run || jogF;
      end
      SPD_FWD_INDEP: begin
        s[SO_FWD]  = run || jogF;
        s[SO_SLOW] = (run && !fast) || jogF || jogR;
      end
    endcase
    return s;
  endfunction

  // [RULE9] Four speed configurations
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      speedOut <= {SPD_N{1'b0}};
      runOut   <= 1'b0;
    end else begin
      speedOut <= speedMap(ctrl_ff[CTRL_SPD +: 2], runFast, isRun,
                           isJog && jogAhead && !ctrl_ff[CTRL_CJOG],
                           isJog && jogBack && !jogAhead && !ctrl_ff[CTRL_CJOG]);
      // [RULE19] Run output follows run state
      runOut   <= isRun;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_ff <= 32'h00000000;
    end else if (regRd) begin
      unique case (regAddr)
        REG_CTRL:       rdData_ff <= {26'h0000000, ctrl_ff};
        REG_LINE_SPEED: rdData_ff <= {16'h0000, lineSpeed_ff};
        REG_PART_LEN:   rdData_ff <= {16'h0000, partLen_ff};
        REG_MIN_TRAVEL: rdData_ff <= {16'h0000, minTravel_ff};
        REG_JOG_SPEED:  rdData_ff <= {24'h000000, jogSpeed_ff};
        REG_ORDER:      rdData_ff <= {16'h0000, piecesLeft_ff};
        REG_CHANGE_PT:  rdData_ff <= {16'h0000, changePt_ff};
        REG_PRESS:      rdData_ff <= {20'h00000, pressCfg_ff};
        REG_GAG_LO:     rdData_ff <= gagCfg_ff[DATA_W-1:0];
        REG_GAG_HI:     rdData_ff <= gagCfg_ff[GAG_N-1:DATA_W];
        REG_STATUS:     rdData_ff <= {26'h0000000, orderDone_ff, overload, !safetyOk, tolFault_ff, isJog, isRun};
        REG_POSITION:   rdData_ff <= {16'h0000, position_ff};
        default:        rdData_ff <= 32'h00000000;
      endcase
    end else begin
      rdData_ff <= 32'h00000000;
    end
  end

  assign regRdData = rdData_ff;
endmodule // csi_sequencer

// ==== src/csi_pkg.sv ====
// Constants and types for the cut line sequencing and interlock block
// How it works
// [RULE1] Simulated run makes encoder pulses from set speed; carriage cycles as normal.
// [RULE2] Simulated run never halts the line on a tolerance fault.
// [RULE3] Suppress-cut option withholds the shear for an tolerance_fault part.
// [RULE4] Shear fires at tolerance or minimum carriage travel, whichever first.
// [RULE5] Carriage jog with jog-ahead moves carriage forward at jog speed.
// [RULE6] Carriage jog with jog-back moves carriage in reverse.
// [RULE7] Outside carriage jog, jog inputs move the roll former instead.
// [RULE8] Halt when final piece trailing end reaches the change point.
// [RULE9] Four selectable speed control output configurations.
// [RULE10] Run and halt follow an external run contact.
// [RULE11] Feed-to-stop: manual press cycle accepted only in halt.
// [RULE12] Non-stop: manual crop accepted while running.
// [RULE13] Automatic shear or press firing only in run state.
// [RULE14] Emergency stop or overload forces halt; only run is dropped, jog is still entered and held with them active.
// [RULE15] Machine type switches select the sequencing logic.
// [RULE16] Encoder movement keeps counting during emergency stop.
// [RULE17] Broken run circuit or open safety interlock drops run.
// [RULE18] Expanded press output addresses 12 presses and 64 gags.
// [RULE19] Run output only with run input, job, no error, interlocks good; job is only checked to start a run, losing it in run keeps run on.
// [RULE20] Pulse generator stops when simulated run ends or line halts.
// [RULE21] Tolerance fault still flagged in status during simulated run.
package csi_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int CNT_W   = 16;
  localparam int JOG_W   = 8;
  localparam int PRESS_N = 12;
  localparam int GAG_N   = 64;
  localparam int SPD_N   = 4;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] REG_LINE_SPEED = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PART_LEN   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_MIN_TRAVEL = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_JOG_SPEED  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_ORDER      = 8'h14;
  localparam logic [ADDR_W-1:0] REG_CHANGE_PT  = 8'h18;
  localparam logic [ADDR_W-1:0] REG_PRESS      = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_GAG_LO     = 8'h20;
  localparam logic [ADDR_W-1:0] REG_GAG_HI     = 8'h24;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h28;
  localparam logic [ADDR_W-1:0] REG_POSITION   = 8'h2c;
  // ****************************************
  // Fields
  // ****************************************
  localparam int CTRL_SIM    = 0;
  localparam int CTRL_NOCUT  = 1;
  localparam int CTRL_CJOG   = 2;
  localparam int CTRL_JOB    = 3;
  localparam int CTRL_SPD    = 4;
  localparam int ST_RUN      = 0;
  localparam int ST_JOG      = 1;
  localparam int ST_TOLF     = 2;
  localparam int ST_ESTOP    = 3;
  localparam int ST_OVL      = 4;
  localparam int ST_DONE     = 5;
  localparam int MT_DIE      = 0;
  localparam int MT_FTS      = 1;
  localparam int SO_FWD      = 0;
  localparam int SO_SLOW     = 1;
  localparam int SO_REV      = 2;
  localparam int SO_RUN      = 3;
  localparam logic [1:0] SPD_FWD_SLOW  = 2'h0;
  localparam logic [1:0] SPD_FAST_SLOW = 2'h1;
  localparam logic [1:0] SPD_RUN_MOVE  = 2'h2;
  localparam logic [1:0] SPD_FWD_INDEP = 2'h3;
  localparam logic [CNT_W-1:0] ONE_PIECE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
  typedef enum logic [2:0] {
    ST_HALT_S = 3'b001,
    ST_RUN_S  = 3'b010,
    ST_JOG_S  = 3'b100
  } csi_state_t;
endpackage

// ==== src/csi_pulse_if.sv ====
// Carrier between the sequencer and the simulated encoder generator
`timescale 1ns/1ps
interface csi_pulse_if;
  import csi_pkg::*;
  logic             enable;
  logic [CNT_W-1:0] increment;
  logic             pulse;
  modport gen  (input enable, input increment, output pulse);
  modport user (output enable, output increment, input pulse);
endinterface

// ==== src/csi_pulse_gen.sv ====
// Simulated line encoder pulse generator
`timescale 1ns/1ps
module csi_pulse_gen
  import csi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  csi_pulse_if.gen pg
);
  logic [CNT_W-1:0] acc_ff;
  logic [CNT_W:0]   nxt_acc;
  logic             pulse_ff;

  assign nxt_acc = {1'b0, acc_ff} + {1'b0, pg.increment};

  // [RULE20] Stops when disabled
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_ff   <= CNT_ZERO;
      pulse_ff <= 1'b0;
    end else if (pg.enable) begin
      acc_ff   <= nxt_acc[CNT_W-1:0];
      pulse_ff <= nxt_acc[CNT_W];
    end else begin
      acc_ff   <= CNT_ZERO;
      pulse_ff <= 1'b0;
    end
  end

  assign pg.pulse = pulse_ff;
endmodule // csi_pulse_gen

// ==== testbench/csi_sequencer_checker.sv ====
// Port-level assertions for the sequencer
`timescale 1ns/1ps
module csi_sequencer_checker
  import csi_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               reset_n,
  input wire logic [1:0]         machineType,
  input wire logic               runContact,
  input wire logic               safetyOk,
  input wire logic               overload,
  input wire logic               runOut,
  input wire logic               shearFire,
  input wire logic               pressFire,
  input wire logic [PRESS_N-1:0] pressSel,
  input wire logic [GAG_N-1:0]   gagSel,
  input wire logic               carriageFwd,
  input wire logic               carriageRev,
  input wire logic               formerFwd,
  input wire logic               formerRev
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ****
  // Interlocks
  // ****
  // State change, then the registered run output
  sequence s_drop;
    ##2 !runOut;
  endsequence
  property p_safety;
    !safetyOk |-> s_drop;
  endproperty
  property p_overload;
    overload |-> s_drop;
  endproperty
  property p_contact;
    !runContact |-> s_drop;
  endproperty
  property p_run_cause;
    $rose(runOut) |-> $past(runContact, 2) && $past(safetyOk, 2) && !$past(overload, 2);
  endproperty
  a_safety: assert property (p_safety) else $error("run kept with safety open");
  a_overload: assert property (p_overload) else $error("run kept on overload");
  a_contact: assert property (p_contact) else $error("run kept with contact open");
  a_run_cause: assert property (p_run_cause) else $error("run without its inputs");
  // ****
  // Firing and jog
  // ****
  property p_shear_run;
    shearFire |-> runOut;
  endproperty
  property p_press_halt;
    pressFire |-> !runOut && machineType[1];
  endproperty
  property p_press_sel;
    !pressFire |-> pressSel == '0 && gagSel == '0;
  endproperty
  property p_cfwd;
    carriageFwd |-> machineType[0] && !carriageRev && !formerFwd && !formerRev;
  endproperty
  property p_crev;
    carriageRev |-> machineType[0] && !formerFwd && !formerRev;
  endproperty
  a_shear_run: assert property (p_shear_run) else $error("shear outside run");
  a_press_halt: assert property (p_press_halt) else $error("press outside halt");
  a_press_sel: assert property (p_press_sel) else $error("select without press");
  a_cfwd: assert property (p_cfwd) else $error("bad carriage forward");
  a_crev: assert property (p_crev) else $error("bad carriage reverse");
endmodule // csi_sequencer_checker

bind csi_sequencer csi_sequencer_checker chk_u (.*);

// ==== testbench/csi_machine_model.sv ====
// Behavioural line encoder and carriage servo
`timescale 1ns/1ps
module csi_machine_model
  import csi_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             lineMove,
  input  wire logic             tolGood,
  input  wire logic             carriageFollow,
  input  wire logic             shearFire,
  output logic                  encPulse,
  output logic                  carriageInTol,
  output logic      [CNT_W-1:0] carriagePos
);
  logic             enc_ff;
  logic [CNT_W-1:0] pos_ff;
  // One count every other cycle, as a real encoder at speed
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) enc_ff <= 1'b0;
    else enc_ff <= lineMove & !enc_ff;
  end
  // Carriage follows line pulses and returns after a cut
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) pos_ff <= CNT_ZERO;
    else if (shearFire) pos_ff <= CNT_ZERO;
    else if (carriageFollow) pos_ff <= pos_ff + CNT_ONE;
  end
  assign encPulse      = enc_ff;
  assign carriagePos   = pos_ff;
  assign carriageInTol = tolGood;
endmodule // csi_machine_model

// ==== testbench/csi_sequencer_bench.sv ====
// Self-checking bench for the sequencer
`timescale 1ns/1ps
module csi_sequencer_bench;
  import csi_pkg::*;
  logic               ref_clk = 1'b0;
  logic               reset_n = 1'b0;
  logic [ADDR_W-1:0]  regAddr = 8'h00;
  logic [DATA_W-1:0]  regWrData = 32'h0, regRdData, rdv, posA;
  logic               regWr = 1'b0, regRd = 1'b0;
  logic [1:0]         machineType = 2'h1;
  logic               runContact = 1'b0, safetyOk = 1'b1, overload = 1'b0;
  logic               jogAhead = 1'b0, jogBack = 1'b0, manualCycle = 1'b0;
  logic               lineMove = 1'b0, tolGood = 1'b1;
  logic               encPulse, carriageInTol, runOut, shearFire, pressFire;
  logic               carriageFollow, carriageFwd, carriageRev, formerFwd, formerRev;
  logic [CNT_W-1:0]   carriagePos;
  logic [SPD_N-1:0]   speedOut;
  logic [PRESS_N-1:0] pressSel, pressSeen = 12'h000;
  logic [GAG_N-1:0]   gagSel, gagSeen = 64'h0;
  logic [JOG_W-1:0]   carriageJogSpeed;
  int                 nMismatch = 0, checksDone = 0, shearCnt = 0, pressCnt = 0, followCnt = 0;
  int                 k, n0;
  always #4 ref_clk = ~ref_clk;
  csi_sequencer dut_u (.*);
  csi_machine_model machine_u (.*);
  // ****
  // Observers
  // ****
  // Counted so that one-cycle pulses are never missed
  always @(posedge ref_clk) begin
    shearCnt <= shearCnt + int'(shearFire === 1'b1);
    pressCnt <= pressCnt + int'(pressFire === 1'b1);
    followCnt <= followCnt + int'(carriageFollow === 1'b1);
    if (pressFire === 1'b1) pressSeen <= pressSel;
    if (pressFire === 1'b1) gagSeen <= gagSel;
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    checksDone++;
    if (g !== e) begin
      nMismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic chkBit(input logic e, input logic g);
    chk({31'h0, e}, {31'h0, g});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    d = regRdData;
    @(posedge ref_clk);
  endtask
  // Bounded wait for the run output to reach a level
  task automatic waitRun(input logic lvl);
    for (int i = 0; i < 400 && runOut !== lvl; i++) @(negedge ref_clk);
    chkBit(lvl, runOut);
    @(posedge ref_clk);
  endtask
  task automatic pulseManual;
    manualCycle <= 1'b1;
    @(posedge ref_clk);
    manualCycle <= 1'b0;
    cyc(4);
  endtask
  task automatic endOfTest;
    if (nMismatch == 0 && checksDone > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    nMismatch++;
    endOfTest();
  end
  // ****
  // Tests
  // ****
  initial begin
    cyc(6);
    reset_n <= 1'b1;
    wr(REG_PART_LEN, 32'h4);
    wr(REG_CHANGE_PT, 32'h2);
    wr(REG_MIN_TRAVEL, 32'h3);
    wr(REG_JOG_SPEED, 32'h2a);
    wr(REG_LINE_SPEED, 32'h4000);
    wr(REG_PRESS, 32'h801);
    wr(REG_GAG_HI, 32'h80000001);
    wr(REG_ORDER, 32'h3);
    wr(REG_CTRL, 32'h8);
    rd(8'h3c, rdv);
    chk(32'h0, rdv);
    runContact <= 1'b1;
    waitRun(1'b1);
    lineMove <= 1'b1;
    waitRun(1'b0);
    chk(32'd2, shearCnt);
    rd(REG_STATUS, rdv);
    chkBit(1'b1, rdv[ST_DONE]);
    // Each interlock in turn: safety, overload, contact
    for (k = 0; k < 3; k++) begin
      lineMove <= 1'b0;
      wr(REG_ORDER, 32'h64);
      waitRun(1'b1);
      lineMove <= 1'b1;
      safetyOk <= (k != 0);
      overload <= (k == 1);
      runContact <= (k != 2);
      cyc(4);
      chkBit(1'b0, runOut);
      rd(REG_STATUS, rdv);
      chkBit(k == 0, rdv[ST_ESTOP]);
      rd(REG_POSITION, posA);
      rd(REG_POSITION, rdv);
      chkBit(1'b1, rdv != posA);
      safetyOk <= 1'b1;
      overload <= 1'b0;
      runContact <= 1'b1;
    end
    // Tolerance fault on the real line; line stopped first so no in-tolerance cut races the count
    waitRun(1'b1);
    lineMove <= 1'b0;
    cyc(4);
    n0 = shearCnt;
    tolGood <= 1'b0;
    lineMove <= 1'b1;
    waitRun(1'b0);
    chk(n0 + 1, shearCnt);
    lineMove <= 1'b0;
    wr(REG_STATUS, 32'h4);
    wr(REG_ORDER, 32'h64);
    wr(REG_CTRL, 32'hb);
    waitRun(1'b1);
    n0 = shearCnt;
    k = followCnt;
    cyc(120);
    chkBit(1'b1, runOut);
    chk(n0, shearCnt);
    chkBit(1'b1, followCnt > k);
    rd(REG_STATUS, rdv);
    chkBit(1'b1, rdv[ST_TOLF]);
    runContact <= 1'b0;
    cyc(6);
    k = followCnt;
    rd(REG_POSITION, posA);
    cyc(40);
    chk(k, followCnt);
    rd(REG_POSITION, rdv);
    chk(posA, rdv);
    wr(REG_STATUS, 32'h4);
    wr(REG_CTRL, 32'h4);
    jogAhead <= 1'b1;
    cyc(4);
    chkBit(1'b1, carriageFwd);
    chk(32'h2a, {24'h0, carriageJogSpeed});
    jogAhead <= 1'b0;
    jogBack <= 1'b1;
    cyc(4);
    chkBit(1'b1, carriageRev);
    jogBack <= 1'b0;
    wr(REG_CTRL, 32'h0);
    jogAhead <= 1'b1;
    cyc(4);
    chkBit(1'b1, formerFwd);
    chkBit(1'b0, carriageFwd);
    jogAhead <= 1'b0;
    // Halt outputs: slow alone in the even configurations, nothing in the odd ones
    for (k = 0; k < 4; k++) begin
      wr(REG_CTRL, 32'(k) << CTRL_SPD);
      cyc(3);
      chk(k[0] ? 32'h0 : 32'h2, {28'h0, speedOut});
    end
    wr(REG_CTRL, 32'h8);
    tolGood <= 1'b1;
    runContact <= 1'b1;
    waitRun(1'b1);
    n0 = shearCnt;
    pulseManual();
    chkBit(1'b1, shearCnt > n0);
    runContact <= 1'b0;
    waitRun(1'b0);
    machineType <= 2'h2;
    pulseManual();
    chk(32'd1, pressCnt);
    chk(32'h801, {20'h0, pressSeen});
    chk(32'h80000001, gagSeen[63:32]);
    runContact <= 1'b1;
    waitRun(1'b1);
    pulseManual();
    chk(32'd1, pressCnt);
    endOfTest();
  end
endmodule // csi_sequencer_bench
